// >>> hdl/duc_defines.vh
// constants for the dual converter update control block
`ifndef DUC_DEFINES_VH
`define DUC_DEFINES_VH
`define DUC_CH0_LOW_ADDR 8'hd2
`define DUC_CH0_HIGH_ADDR 8'hd3
`define DUC_CH0_CTRL_ADDR 8'hd4
`define DUC_CH1_LOW_ADDR 8'hd5
`define DUC_CH1_HIGH_ADDR 8'hd6
`define DUC_CH1_CTRL_ADDR 8'hd7
`define DUC_BYTE_RESET 8'h00
`define DUC_CODE_RESET 12'h000
`define DUC_CTRL_EN_BIT 7
`define DUC_CTRL_MODE_HI 4
`define DUC_CTRL_MODE_LO 3
`define DUC_CTRL_FMT_HI 2
`define DUC_CTRL_FMT_LO 0
`define DUC_CTRL_WMASK 8'h9f
`define DUC_MODE_ONDEMAND 2'b00
`define DUC_MODE_TMR3 2'b01
`define DUC_MODE_TMR4 2'b10
`define DUC_MODE_TMR2 2'b11
`define DUC_FMT_SHIFT0 3'b000
`define DUC_FMT_SHIFT1 3'b001
`define DUC_FMT_SHIFT2 3'b010
`define DUC_FMT_SHIFT3 3'b011
`endif

// >>> hdl/duc_buffer.v
// two-entry valid/ready buffer for converter codes
`timescale 1ns/1ps
module duc_buffer #(
    parameter WIDTH = 12
) (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // draining side
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:1];
    reg [1:0] count_q;
    reg wr_ptr_q;
    reg rd_ptr_q;
    wire push;
    wire pop;

    assign in_ready = (count_q != 2'd2);
    assign out_valid = (count_q != 2'd0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @* begin
        out_data = mem_q[rd_ptr_q];
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mem_q[0] <= {WIDTH{1'b0}};
            mem_q[1] <= {WIDTH{1'b0}};
            count_q <= 2'd0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_data;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'd1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'd1;
            end
        end
    end
endmodule

// >>> hdl/duc_top.v
// two-channel converter data, update scheduling and format control
`timescale 1ns/1ps
`include "duc_defines.vh"
// Summary of operation
// - two channels, 12-bit codes 000 to fff
// - each channel enabled by own control register
// - disabled channel: output floats, converter powered down
// - low byte reads last software write
// - high byte reads converter high latch
// - mode bits 4:3, 00 default on-demand
// - on-demand: low byte write held only
// - on-demand: high byte write moves word
// - timer modes hold both byte writes
// - modes 01,10,11 pick timers 3,4,2
// - timer overflow copies both bytes together
// - format bits 2:0 pick five placements
// - second channel identical, own registers
module duc_top #(
    parameter CODE_W = 12
) (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // special function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata,
    // timer overflow strobes
    input wire tmr2_ovf,
    input wire tmr3_ovf,
    input wire tmr4_ovf,
    // converter cores, channel 1 in the upper half
    input wire [1:0] conv_ready,
    output wire [1:0] conv_valid,
    output wire [2*CODE_W-1:0] conv_code,
    output wire [1:0] conv_out_en,
    output wire [1:0] conv_power_down
);
    wire [7:0] rd_val [0:1];
    wire [1:0] rd_hit;
    reg [7:0] rdata_d;

    function [CODE_W-1:0] place_word;
        input [2:0] fmt;
        input [7:0] hi;
        input [7:0] lo;
        reg [15:0] pair;
        begin
            pair = {hi, lo};
            case (fmt)
                `DUC_FMT_SHIFT0: place_word = pair[11:0];
                `DUC_FMT_SHIFT1: place_word = pair[12:1];
                `DUC_FMT_SHIFT2: place_word = pair[13:2];
                `DUC_FMT_SHIFT3: place_word = pair[14:3];
                default: place_word = pair[15:4];
            endcase
        end
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            // per-channel register addresses
            wire [7:0] a_low;
            wire [7:0] a_high;
            wire [7:0] a_ctrl;

            // control and holding registers
            reg [7:0] ctrl_q;
            reg [7:0] ctrl_d;
            reg [7:0] low_hold_q;
            reg [7:0] low_hold_d;
            reg [7:0] high_hold_q;
            reg [7:0] high_hold_d;

            // converter input latches and pending transfer
            reg [7:0] low_lat_q;
            reg [7:0] low_lat_d;
            reg [7:0] high_lat_q;
            reg [7:0] high_lat_d;
            reg pend_q;
            reg trigger;
            reg [7:0] rd_byte;
            reg rd_match;

            // decoded strobes and buffer handshake
            wire wr_low;
            wire wr_high;
            wire wr_ctrl;
            wire fire;
            wire xfer;
            wire pend_d;
            wire enabled;
            wire [CODE_W-1:0] word_in;
            wire buf_in_ready;
            wire [CODE_W-1:0] buf_out;
            wire [1:0] mode;

            assign a_low = (ch == 0) ? `DUC_CH0_LOW_ADDR : `DUC_CH1_LOW_ADDR;
            assign a_high = (ch == 0) ? `DUC_CH0_HIGH_ADDR : `DUC_CH1_HIGH_ADDR;
            assign a_ctrl = (ch == 0) ? `DUC_CH0_CTRL_ADDR : `DUC_CH1_CTRL_ADDR;
            assign wr_low = sfr_wr && (sfr_addr == a_low);
            assign wr_high = sfr_wr && (sfr_addr == a_high);
            assign wr_ctrl = sfr_wr && (sfr_addr == a_ctrl);
            assign mode = ctrl_q[`DUC_CTRL_MODE_HI:`DUC_CTRL_MODE_LO];

            always @* begin
                ctrl_d = wr_ctrl ? (sfr_wdata & `DUC_CTRL_WMASK) : ctrl_q;
                low_hold_d = wr_low ? sfr_wdata : low_hold_q;
                high_hold_d = wr_high ? sfr_wdata : high_hold_q;
            end

            // update trigger selection
            always @* begin
                case (mode)
                    `DUC_MODE_ONDEMAND: trigger = wr_high;
                    `DUC_MODE_TMR3: trigger = tmr3_ovf;
                    `DUC_MODE_TMR4: trigger = tmr4_ovf;
                    `DUC_MODE_TMR2: trigger = tmr2_ovf;
                    default: trigger = 1'b0;
                endcase
            end

            // a trigger waits while the buffer is full
            assign fire = trigger || pend_q;
            assign xfer = fire && buf_in_ready;
            assign pend_d = fire && !buf_in_ready;

            // converter input latches take both held bytes in one cycle
            always @* begin
                low_lat_d = xfer ? low_hold_d : low_lat_q;
                high_lat_d = xfer ? high_hold_d : high_lat_q;
            end

            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    ctrl_q <= `DUC_BYTE_RESET;
                    low_hold_q <= `DUC_BYTE_RESET;
                    high_hold_q <= `DUC_BYTE_RESET;
                    low_lat_q <= `DUC_BYTE_RESET;
                    high_lat_q <= `DUC_BYTE_RESET;
                    pend_q <= 1'b0;
                end else begin
                    ctrl_q <= ctrl_d;
                    low_hold_q <= low_hold_d;
                    high_hold_q <= high_hold_d;
                    low_lat_q <= low_lat_d;
                    high_lat_q <= high_lat_d;
                    pend_q <= pend_d;
                end
            end

            // code word placed from the latch inputs of this cycle
            assign word_in = place_word(ctrl_q[`DUC_CTRL_FMT_HI:`DUC_CTRL_FMT_LO],
                high_lat_d, low_lat_d);

            duc_buffer #(
                .WIDTH(CODE_W)
            ) u_buf (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .in_valid(fire),
                .in_ready(buf_in_ready),
                .in_data(word_in),
                .out_valid(conv_valid[ch]),
                .out_ready(conv_ready[ch]),
                .out_data(buf_out)
            );

            assign enabled = ctrl_q[`DUC_CTRL_EN_BIT];
            assign conv_code[ch*CODE_W +: CODE_W] = buf_out;
            assign conv_out_en[ch] = enabled;
            assign conv_power_down[ch] = ~enabled;

            // read selection for this channel's three registers
            always @* begin
                rd_match = 1'b1;
                rd_byte = `DUC_BYTE_RESET;
                if (sfr_addr == a_low) begin
                    rd_byte = low_hold_q;
                end else if (sfr_addr == a_high) begin
                    rd_byte = high_lat_q;
                end else if (sfr_addr == a_ctrl) begin
                    rd_byte = ctrl_q;
                end else begin
                    rd_match = 1'b0;
                end
            end

            assign rd_hit[ch] = rd_match;
            assign rd_val[ch] = rd_byte;
        end
    endgenerate

    // read data holds between reads, zero for unmapped addresses
    always @* begin
        rdata_d = sfr_rdata;
        if (sfr_rd) begin
            if (rd_hit[0]) begin
                rdata_d = rd_val[0];
            end else if (rd_hit[1]) begin
                rdata_d = rd_val[1];
            end else begin
                rdata_d = `DUC_BYTE_RESET;
            end
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= `DUC_BYTE_RESET;
        end else begin
            sfr_rdata <= rdata_d;
        end
    end
endmodule

// >>> verif/duc_top_properties.sv
// assertion checker for the converter update control block
`timescale 1ns/1ps
module duc_top_properties #(parameter CODE_W = 12) (
    // clock, reset and register port
    input wire ref_clk, input wire rstn, input wire [7:0] sfr_addr, input wire sfr_wr,
    input wire [7:0] sfr_wdata, input wire sfr_rd, input wire [7:0] sfr_rdata,
    // timers and converters
    input wire tmr2_ovf, input wire tmr3_ovf, input wire tmr4_ovf, input wire [1:0] conv_ready,
    input wire [1:0] conv_valid, input wire [2*CODE_W-1:0] conv_code,
    input wire [1:0] conv_out_en, input wire [1:0] conv_power_down
);
    reg [7:0] lo_q;
    reg [1:0] md_q;
    wire tsel = md_q == 2'b01 ? tmr3_ovf : md_q == 2'b10 ? tmr4_ovf : md_q == 2'b11 && tmr2_ovf;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lo_q <= 8'h00;
            md_q <= 2'b00;
        end else begin
            if (sfr_wr && sfr_addr == 8'hd2) lo_q <= sfr_wdata;
            if (sfr_wr && sfr_addr == 8'hd4) md_q <= sfr_wdata[4:3];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_wr(a); sfr_wr && sfr_addr == a; endsequence
    sequence s_rd(a); sfr_rd && sfr_addr == a; endsequence
    chk_ch0_enable: assert property (s_wr(8'hd4) |=>
        conv_out_en[0] == $past(sfr_wdata[7]) && conv_power_down[0] != $past(sfr_wdata[7]))
        else $error("ch0 enable");
    chk_ch1_enable: assert property (s_wr(8'hd7) |=>
        conv_out_en[1] == $past(sfr_wdata[7]) && conv_power_down[1] != $past(sfr_wdata[7]))
        else $error("ch1 enable");
    chk_low_read: assert property (s_rd(8'hd2) |=> sfr_rdata == $past(lo_q))
        else $error("low read");
    chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    chk_code_stands: assert property (conv_valid[0] && !conv_ready[0] |=>
        conv_valid[0] && $stable(conv_code[11:0])) else $error("code not held");
    chk_push_cause: assert property ($rose(conv_valid[0]) |->
        $past(sfr_wr && sfr_addr == 8'hd3 || tmr2_ovf || tmr3_ovf || tmr4_ovf))
        else $error("push without trigger");
    chk_high_push: assert property (s_wr(8'hd3) ##0 (md_q == 2'b00 && !conv_valid[0]) |=>
        conv_valid[0]) else $error("no push on high write");
    chk_timer_push: assert property (tsel && !conv_valid[0] |=> conv_valid[0])
        else $error("no push on timer");
endmodule
bind duc_top duc_top_properties #(.CODE_W(CODE_W)) chk_u (.ref_clk(ref_clk), .rstn(rstn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf), .tmr4_ovf(tmr4_ovf),
    .conv_ready(conv_ready), .conv_valid(conv_valid), .conv_code(conv_code),
    .conv_out_en(conv_out_en), .conv_power_down(conv_power_down));

// >>> verif/duc_conv_model.sv
// converter core model: takes codes, may stall
`timescale 1ns/1ps
module duc_conv_model (
    input wire ref_clk, input wire rstn, input wire stall,
    input wire valid, input wire [11:0] code, output wire ready,
    output reg [11:0] last_q, output integer count_q
);
    assign ready = !stall;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            last_q <= 12'h000;
            count_q <= 0;
        end else if (valid && ready) begin
            last_q <= code;
            count_q <= count_q + 1;
        end
    end
endmodule

// >>> verif/tb.sv
// self-checking bench for the converter update control block
`timescale 1ns/1ps
module tb;
    reg ref_clk, rstn, sfr_wr, sfr_rd, tmr2_ovf, tmr3_ovf, tmr4_ovf;
    reg [7:0] sfr_addr, sfr_wdata;
    reg [1:0] stall;
    reg [19:0] rows [0:5];
    wire [7:0] sfr_rdata;
    wire [1:0] rdy, vld, oe, pd;
    wire [23:0] code;
    wire [11:0] last0, last1;
    wire [31:0] cnt0, cnt1;
    integer fail_count, check_count, i, t, n, cyc = 0;
    duc_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .tmr2_ovf(tmr2_ovf),
        .tmr3_ovf(tmr3_ovf), .tmr4_ovf(tmr4_ovf), .conv_ready(rdy), .conv_valid(vld),
        .conv_code(code), .conv_out_en(oe), .conv_power_down(pd));
    duc_conv_model m0_u (.ref_clk(ref_clk), .rstn(rstn), .stall(stall[0]), .valid(vld[0]),
        .code(code[11:0]), .ready(rdy[0]), .last_q(last0), .count_q(cnt0));
    duc_conv_model m1_u (.ref_clk(ref_clk), .rstn(rstn), .stall(stall[1]), .valid(vld[1]),
        .code(code[23:12]), .ready(rdy[1]), .last_q(last1), .count_q(cnt1));
    task chk(input string what, input [11:0] exp, input [11:0] seen);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge ref_clk);
            sfr_addr = a;
            sfr_wdata = d;
            sfr_wr = 1'b1;
            @(negedge ref_clk);
            sfr_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(negedge ref_clk);
            sfr_addr = a;
            sfr_rd = 1'b1;
            @(negedge ref_clk);
            sfr_rd = 1'b0;
            chk("read", {4'h0, exp}, {4'h0, sfr_rdata});
        end
    endtask
    task pulse(input integer k);
        begin
            @(negedge ref_clk);
            {tmr2_ovf, tmr3_ovf, tmr4_ovf} = {k == 2, k == 3, k == 4};
            @(negedge ref_clk);
            {tmr2_ovf, tmr3_ovf, tmr4_ovf} = 3'b000;
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count = fail_count + 1;
            wrap_up;
        end
    end
    initial begin
        {sfr_wr, sfr_rd, tmr2_ovf, tmr3_ovf, tmr4_ovf, stall, rstn} = 8'h00;
        {sfr_addr, sfr_wdata, fail_count, check_count} = 0;
        // control value and expected code for high ab, low cd
        rows[0] = {8'he0, 12'hbcd};
        rows[1] = {8'h89, 12'h5e6};
        rows[2] = {8'h92, 12'haf3};
        rows[3] = {8'h9b, 12'h579};
        rows[4] = {8'h84, 12'habc};
        rows[5] = {8'h07, 12'habc};
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        chk("power down", 12'h003, {10'h0, pd});
        rd(8'hd3, 8'h00);
        $display("reset done");
        for (i = 0; i < 6; i = i + 1) begin
            n = cnt0;
            wr(8'hd4, rows[i][19:12]);
            wr(8'hd2, 8'h00);
            wr(8'hd2, 8'hcd);
            chk("held", 12'(n), 12'(cnt0));
            wr(8'hd3, 8'hab);
            t = rows[i][16:15] == 1 ? 3 : rows[i][16:15] == 2 ? 4 : 2;
            if (rows[i][16:15] != 2'b00) begin
                pulse(t == 2 ? 3 : 2);
                pulse(t == 4 ? 3 : 4);
                chk("held", 12'(n), 12'(cnt0));
                pulse(t);
            end
            repeat (3) @(negedge ref_clk);
            chk("code", rows[i][11:0], last0);
            chk("count", 12'(n + 1), 12'(cnt0));
            chk("enable", {10'h0, ~rows[i][19], rows[i][19]}, {10'h0, pd[0], oe[0]});
            rd(8'hd4, rows[i][19:12] & 8'h9f);
            rd(8'hd2, 8'hcd);
            $display("row %0d done", i);
        end
        wr(8'hd4, 8'h88);
        wr(8'hd2, 8'hff);
        wr(8'hd3, 8'hff);
        rd(8'hd3, 8'hab);
        pulse(3);
        repeat (3) @(negedge ref_clk);
        chk("full scale", 12'hfff, last0);
        $display("full scale done");
        stall = 2'b01;
        n = cnt0;
        wr(8'hd4, 8'h80);
        for (i = 1; i < 5; i = i + 1) wr(8'hd3, 8'(i));
        chk("stalled", 12'(n), 12'(cnt0));
        stall = 2'b00;
        repeat (5) @(negedge ref_clk);
        chk("drained", 12'(n + 3), 12'(cnt0));
        chk("merged", 12'h4ff, last0);
        $display("buffer done");
        wr(8'hd7, 8'h80);
        wr(8'hd5, 8'h21);
        wr(8'hd6, 8'h43);
        repeat (3) @(negedge ref_clk);
        chk("ch1 code", 12'h321, last1);
        rd(8'hd8, 8'h00);
        $display("channel 1 done");
        wrap_up;
    end
endmodule
